// [hdl/ddr_pin_iface.sv]
`timescale 1ns/1ps
module ddr_pin_iface import ddr_pin_pkg::*; #(
	parameter int DQ_W     = 8,
	parameter int ROW_BITS = 2,
	parameter int COL_BITS = 3,
	parameter int RLAT     = RD_LAT,
	parameter int BDEPTH   = BUF_DEPTH
) (
	input  wire logic              sys_clk,      // core clock
	input  wire logic              rstn,         // async reset, active low
	input  wire logic              ce,           // clock enable, freezes state when low
	input  wire logic              ck_t,         // link clock, true phase
	input  wire logic              cke,          // memory clock enable pin
	input  wire logic              cs_n,         // chip select
	input  wire logic              ras_n,        // row strobe
	input  wire logic              cas_n,        // column strobe
	input  wire logic              we_n,         // write enable
	input  wire logic [BA_W-1:0]   ba,           // bank address
	input  wire logic [ADDR_W-1:0] addr,         // address
	input  wire logic              dm,           // write data mask
	input  wire logic [DQ_W-1:0]   dq_i,         // data pin in
	output logic      [DQ_W-1:0]   dq_o,         // data pin out
	output logic                   dq_oe,        // data pin drive
	input  wire logic              dqs_i,        // strobe pin in
	output logic                   dqs_o,        // strobe pin out
	output logic                   dqs_oe,       // strobe pin drive
	output logic      [ADDR_W-1:0] mode_reg,     // base mode register
	output logic      [ADDR_W-1:0] ext_mode_reg, // extended mode register
	output logic                   power_down,   // core view: in power-down
	output logic                   self_refresh  // core view: in self refresh
);

	localparam int IX_W = BA_W + ROW_BITS + COL_BITS - 1;
	localparam int E_W  = IX_W + 2 * DQ_W + 2;
	localparam int P_W  = (BDEPTH > 1) ? $clog2(BDEPTH) : 1;

	function automatic logic [P_W-1:0] ptr_inc(input logic [P_W-1:0] p);
		return (p == P_W'(BDEPTH - 1)) ? '0 : P_W'(p + 1'b1);
	endfunction

	// =====================================================
	// crossings into the link domain
	logic ce_m_q, ce_l_q, srx_m_q, srx_l_q, srx_q;
	always_ff @(posedge ck_t or negedge rstn) begin
		if (!rstn) begin
			ce_m_q  <= 1'b0;
			ce_l_q  <= 1'b0;
			srx_m_q <= 1'b0;
			srx_l_q <= 1'b0;
		end else begin
			ce_m_q  <= ce;
			ce_l_q  <= ce_m_q;
			srx_m_q <= srx_q;
			srx_l_q <= srx_m_q;
		end
	end

	// =====================================================
	// command decode and power state
	cmd_t                  cmd;
	pwr_t                  pwr_q, pwr_d;
	logic [BANKS-1:0]      open_q, open_d;
	logic [ROW_BITS-1:0]   row_q [BANKS];
	logic [ROW_BITS-1:0]   row_d [BANKS];
	logic [ADDR_W-1:0]     mode_q, mode_d, emode_q, emode_d;
	logic                  pd_q, pd_d, sr_q, sr_d;
	logic                  live;
	logic [RLAT-1:0]       rdv_q, rdv_d;
	logic [IX_W-1:0]       rdix_q [RLAT];
	logic [IX_W-1:0]       rdix_d [RLAT];
	logic [1:0]            wrv_q, wrv_d;
	logic [IX_W-1:0]       wrix_q [2];
	logic [IX_W-1:0]       wrix_d [2];
	logic [IX_W-1:0]       cur_ix;

	assign cmd    = decode_cmd(cs_n, ras_n, cas_n, we_n);
	assign live   = (pwr_q == PW_RUN) && cke;
	assign cur_ix = {ba, row_q[ba], addr[COL_BITS-1:1]};

	always_comb begin
		pwr_d   = pwr_q;
		open_d  = open_q;
		row_d   = row_q;
		mode_d  = mode_q;
		emode_d = emode_q;
		rdv_d   = {rdv_q[RLAT-2:0], 1'b0};
		rdix_d  = rdix_q;
		for (int i = RLAT - 1; i > 0; i--) begin
			rdix_d[i] = rdix_q[i-1];
		end
		wrv_d     = {wrv_q[0], 1'b0};
		wrix_d[1] = wrix_q[0];
		wrix_d[0] = wrix_q[0];
		case (pwr_q)
			PW_RUN: begin
				if (!cke) begin
					if (cmd == C_REF) begin
						pwr_d = PW_SREF;
					end else if (|open_q) begin
						pwr_d = PW_APD;
					end else begin
						pwr_d = PW_PPD;
					end
				end
			end
			PW_PPD, PW_APD: begin
				if (cke) begin
					pwr_d = PW_RUN;
				end
			end
			PW_SREF: begin
				if (srx_l_q) begin
					pwr_d = PW_RUN;
				end
			end
			default: pwr_d = PW_RUN;
		endcase
		if (live) begin
			case (cmd)
				C_ACT: begin
					open_d[ba] = 1'b1;
					row_d[ba]  = addr[ROW_BITS-1:0];
				end
				C_PRE: begin
					if (addr[AP_BIT]) begin
						open_d = '0;
					end else begin
						open_d[ba] = 1'b0;
					end
				end
				C_MRS: begin
					if (ba == BA_MR) begin
						mode_d = addr;
					end else if (ba == BA_EMR) begin
						emode_d = addr;
					end
				end
				C_RD: begin
					rdv_d[0]  = 1'b1;
					rdix_d[0] = cur_ix;
					if (addr[AP_BIT]) begin
						open_d[ba] = 1'b0;
					end
				end
				C_WR: begin
					wrv_d[0]  = 1'b1;
					wrix_d[0] = cur_ix;
					if (addr[AP_BIT]) begin
						open_d[ba] = 1'b0;
					end
				end
				default: ;
			endcase
		end
		pd_d = (pwr_d == PW_PPD) || (pwr_d == PW_APD);
		sr_d = (pwr_d == PW_SREF);
	end

	always_ff @(posedge ck_t or negedge rstn) begin
		if (!rstn) begin
			pwr_q   <= PW_RUN;
			open_q  <= '0;
			row_q   <= '{default: '0};
			mode_q  <= MODE_RST;
			emode_q <= MODE_RST;
			pd_q    <= 1'b0;
			sr_q    <= 1'b0;
			rdv_q   <= '0;
			rdix_q  <= '{default: '0};
			wrv_q   <= '0;
			wrix_q  <= '{default: '0};
		end else if (ce_l_q) begin
			pwr_q   <= pwr_d;
			open_q  <= open_d;
			row_q   <= row_d;
			mode_q  <= mode_d;
			emode_q <= emode_d;
			pd_q    <= pd_d;
			sr_q    <= sr_d;
			rdv_q   <= rdv_d;
			rdix_q  <= rdix_d;
			wrv_q   <= wrv_d;
			wrix_q  <= wrix_d;
		end
	end

	assign mode_reg     = mode_q;
	assign ext_mode_reg = emode_q;

	// =====================================================
	// write capture on both strobe edges
	logic [DQ_W:0] dqs_r_q, dqs_f_q;
	always_ff @(posedge dqs_i or negedge rstn) begin
		if (!rstn) begin
			dqs_r_q <= '0;
		end else begin
			dqs_r_q <= {dm, dq_i};
		end
	end
	always_ff @(negedge dqs_i or negedge rstn) begin
		if (!rstn) begin
			dqs_f_q <= '0;
		end else begin
			dqs_f_q <= {dm, dq_i};
		end
	end

	// =====================================================
	// two-entry write buffer between capture and array
	logic [E_W-1:0] fifo_q [BDEPTH];
	logic [E_W-1:0] fifo_d [BDEPTH];
	logic [P_W-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [P_W:0]   cnt_q, cnt_d;
	logic [E_W-1:0] pend_q, pend_d, head;
	logic           pend_v_q, pend_v_d;
	logic           in_valid, in_ready, out_valid, out_ready;

	assign in_valid  = pend_v_q;
	assign in_ready  = (cnt_q != (P_W+1)'(BDEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_ready = live;
	assign head      = fifo_q[rp_q];

	always_comb begin
		fifo_d   = fifo_q;
		wp_d     = wp_q;
		rp_d     = rp_q;
		cnt_d    = cnt_q;
		pend_d   = pend_q;
		pend_v_d = pend_v_q;
		if (in_valid && in_ready) begin
			fifo_d[wp_q] = pend_q;
			wp_d         = ptr_inc(wp_q);
			pend_v_d     = 1'b0;
		end
		if (out_valid && out_ready) begin
			rp_d = ptr_inc(rp_q);
		end
		cnt_d = cnt_q + (P_W+1)'(in_valid && in_ready) - (P_W+1)'(out_valid && out_ready);
		if (wrv_q[1] && (pwr_q == PW_RUN) && !pend_v_d) begin // drops the write while buffer full holds the pending entry
			pend_d   = {wrix_q[1], dqs_f_q[DQ_W-1:0], dqs_r_q[DQ_W-1:0], dqs_f_q[DQ_W], dqs_r_q[DQ_W]};
			pend_v_d = 1'b1;
		end
	end

	always_ff @(posedge ck_t or negedge rstn) begin
		if (!rstn) begin
			fifo_q   <= '{default: '0};
			wp_q     <= '0;
			rp_q     <= '0;
			cnt_q    <= '0;
			pend_q   <= '0;
			pend_v_q <= 1'b0;
		end else if (ce_l_q) begin
			fifo_q   <= fifo_d;
			wp_q     <= wp_d;
			rp_q     <= rp_d;
			cnt_q    <= cnt_d;
			pend_q   <= pend_d;
			pend_v_q <= pend_v_d;
		end
	end

	// =====================================================
	// storage array
	logic [DQ_W-1:0] mem [2**(IX_W+1)];
	always_ff @(posedge ck_t) begin
		if (ce_l_q && out_valid && out_ready) begin
			if (!head[0]) begin
				mem[{head[E_W-1 -: IX_W], 1'b0}] <= head[2 +: DQ_W];
			end
			if (!head[1]) begin
				mem[{head[E_W-1 -: IX_W], 1'b1}] <= head[2+DQ_W +: DQ_W];
			end
		end
	end

	// =====================================================
	// read output, one word per clock half
	logic [DQ_W-1:0] w0_q, w0_d, w1_q, w1_d;
	logic            oe_q, oe_d;

	always_comb begin
		w0_d = w0_q;
		w1_d = w1_q;
		oe_d = 1'b0;
		if (rdv_q[RLAT-1] && cke) begin
			w0_d = mem[{rdix_q[RLAT-1], 1'b0}];
			w1_d = mem[{rdix_q[RLAT-1], 1'b1}];
			oe_d = 1'b1;
		end
	end

	always_ff @(posedge ck_t or negedge rstn) begin
		if (!rstn) begin
			w0_q <= '0;
			w1_q <= '0;
			oe_q <= 1'b0;
		end else if (ce_l_q) begin
			w0_q <= w0_d;
			w1_q <= w1_d;
			oe_q <= oe_d;
		end
	end

	assign dq_o   = ck_t ? w0_q : w1_q;
	assign dq_oe  = oe_q;
	assign dqs_o  = ck_t & oe_q;
	assign dqs_oe = oe_q;

	// =====================================================
	// core domain: self-refresh exit without the link clock
	logic cke_m_q, cke_s_q, sr_m_q, sr_s_q, pd_m_q, pd_s_q, srx_d;

	always_comb begin
		srx_d = sr_s_q && cke_s_q;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cke_m_q <= 1'b0;
			cke_s_q <= 1'b0;
			sr_m_q  <= 1'b0;
			sr_s_q  <= 1'b0;
			pd_m_q  <= 1'b0;
			pd_s_q  <= 1'b0;
			srx_q   <= 1'b0;
		end else if (ce) begin
			cke_m_q <= cke;
			cke_s_q <= cke_m_q;
			sr_m_q  <= sr_q;
			sr_s_q  <= sr_m_q;
			pd_m_q  <= pd_q;
			pd_s_q  <= pd_m_q;
			srx_q   <= srx_d;
		end
	end

	assign power_down   = pd_s_q;
	assign self_refresh = sr_s_q;

endmodule // ddr_pin_iface

// [hdl/ddr_pin_pkg.sv]
// Function
// - Address and control pins are sampled only on the rising crossing of the true clock.
// - Read data leaves the pins one word per half clock, timed to both clock crossings.
// - Clock enable high runs clocks, input buffers and drivers; low switches them off.
// - Clock enable falling with all banks idle gives precharge power-down or self refresh, else active power-down;
//   the code enters self refresh on a refresh command even with a bank open.
// - Clock enable is synchronous for power-down entry and exit and self-refresh entry, asynchronous for self-refresh exit.
// - Power-down keeps only the clock pair and clock enable alive; self refresh keeps only clock enable.
// - A command is ignored on any edge where chip select is registered high.
// - The command is decoded from row strobe, column strobe and write enable with chip select on one edge.
// - The data mask is sampled on both strobe edges and a masked write word is not stored.
// - Bank address picks the bank for activate, read, write and single precharge, and the mode register on a mode set.
// - Address carries the row on activate, column and auto-precharge on read or write, and the opcode on a mode set.
// - On precharge, address bit ten low closes the addressed bank and high closes every bank.
// - The memory drives the strobe edge-aligned with read data and captures write data with the centred strobe.
// - Write data is registered on both the rising and falling strobe edges.
// - Data and strobe stay released after reset and are driven only during a read.
package ddr_pin_pkg;

	// =====================================================
	// pin geometry
	localparam int ADDR_W  = 13;
	localparam int BA_W    = 2;
	localparam int BANKS   = 4;
	localparam int AP_BIT  = 10;

	// =====================================================
	// reset value, mode register selects, read latency (link clock cycles) and write buffer depth (entries)
	localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
	localparam logic [BA_W-1:0]   BA_MR    = 2'h0;
	localparam logic [BA_W-1:0]   BA_EMR   = 2'h1;
	localparam int                RD_LAT   = 2;
	localparam int                BUF_DEPTH = 2;

	// =====================================================
	// commands and power states
	typedef enum {C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_REF, C_MRS, C_BST} cmd_t;
	typedef enum {PW_RUN, PW_PPD, PW_APD, PW_SREF} pwr_t;

	function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n, input logic cas_n,
		input logic we_n);
		cmd_t c;
		c = C_NOP;
		if (!cs_n) begin
			case ({ras_n, cas_n, we_n})
				3'h3:    c = C_ACT;
				3'h5:    c = C_RD;
				3'h4:    c = C_WR;
				3'h2:    c = C_PRE;
				3'h1:    c = C_REF;
				3'h0:    c = C_MRS;
				3'h6:    c = C_BST;
				default: c = C_NOP;
			endcase
		end
		return c;
	endfunction

endpackage

// [verification/ddr_pin_chk.sv]
`timescale 1ns/1ps
// ==========
// pin checks, link domain
module ddr_pin_chk import ddr_pin_pkg::*; (
	input wire logic              ck_t,         // link clock
	input wire logic              rstn,         // reset, low
	input wire logic              ce,           // clock enable of the block
	input wire logic              cke,          // clock enable
	input wire logic              cs_n,         // select
	input wire logic              ras_n,        // row strobe
	input wire logic              cas_n,        // column strobe
	input wire logic              we_n,         // write enable
	input wire logic [BA_W-1:0]   ba,           // bank
	input wire logic [ADDR_W-1:0] addr,         // address
	input wire logic              dq_oe,        // data drive
	input wire logic              dqs_o,        // strobe out
	input wire logic              dqs_oe,       // strobe drive
	input wire logic [ADDR_W-1:0] mode_reg,     // base mode
	input wire logic [ADDR_W-1:0] ext_mode_reg, // ext mode
	input wire logic              power_down,   // power-down
	input wire logic              self_refresh  // self refresh
);
	wire logic live = ce && cke && !power_down && !self_refresh;
	wire logic rd   = !cs_n && ras_n && !cas_n && we_n;
	wire logic mrs  = !cs_n && !ras_n && !cas_n && !we_n;
	wire logic rf   = !cs_n && !ras_n && !cas_n && we_n;
	default clocking @(posedge ck_t); endclocking
	default disable iff (!rstn);
	oe_pair_a: assert property (dq_oe == dqs_oe)
		else $error("strobe and data drive differ");
	strobe_edge_a: assert property (@(negedge ck_t) dqs_oe |-> dqs_o)
		else $error("strobe not aligned to clock");
	rd_lat_a: assert property (rd && live ##1 cke [*3] |-> dq_oe)
		else $error("read data missing");
	oe_cause_a: assert property (dq_oe |-> $past(rd, 3))
		else $error("data driven without read");
	mode_base_a: assert property (mrs && live && ba == BA_MR |=> mode_reg == $past(addr) && $stable(ext_mode_reg))
		else $error("base mode not loaded");
	mode_ext_a: assert property (mrs && live && ba == BA_EMR |=> ext_mode_reg == $past(addr) && $stable(mode_reg))
		else $error("ext mode not loaded");
	pd_entry_a: assert property (cke ##1 (!cke && cs_n) ##1 !cke [*2] |-> power_down && !self_refresh)
		else $error("power-down not entered");
	sref_a: assert property (cke ##1 (!cke && rf) ##1 !cke [*2] |-> self_refresh && !power_down)
		else $error("self refresh not entered");
	cke_off_a: assert property (!cke |=> !dq_oe)
		else $error("data driven with clock enable low");
	desel_a: assert property (cs_n |=> $stable(mode_reg) && $stable(ext_mode_reg))
		else $error("deselected command took effect");
	cover property (rd && live);
	cover property (mrs && live && ba == BA_EMR);
	cover property (self_refresh);
endmodule // ddr_pin_chk

// [verification/ddr_ctrl_model.sv]
`timescale 1ns/1ps
// ==========
// controller side of the pins
module ddr_ctrl_model import ddr_pin_pkg::*; (
	input  wire logic ck_t,              // link clock
	output logic      cke,               // clock enable
	output logic      cs_n,              // select
	output logic      ras_n,             // row strobe
	output logic      cas_n,             // column strobe
	output logic      we_n,              // write enable
	output logic      [BA_W-1:0]   ba,   // bank
	output logic      [ADDR_W-1:0] addr, // address
	output logic      dm,                // write mask
	output logic      [7:0]        dq,   // data when driving
	output logic      dqs                // strobe when driving
);
	initial begin
		{cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
		ba = 2'h0;
		addr = 13'h0000;
		{dm, dq, dqs} = 10'h000;
	end
	// one command per link cycle, set at the falling edge
	task automatic cmd(input logic [3:0] c, input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input logic k);
		@(negedge ck_t);
		{cs_n, ras_n, cas_n, we_n} = c;
		ba = b;
		addr = a;
		cke = k;
	endtask
	// write burst, strobe centred in each word
	task automatic wr(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [1:0] m);
		cmd(4'h4, b, a, 1'b1);
		cmd(4'hF, b, a, 1'b1);
		dq = d[15:8];
		dm = m[1];
		#32 dqs = 1'b1;
		#16 dq = d[7:0];
		dm = m[0];
		#16 dqs = 1'b0;
		#16 dq = ~dq;
	endtask
endmodule // ddr_ctrl_model

// [verification/test_ddr_sdram_pin_interface.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module test_ddr_sdram_pin_interface import ddr_pin_pkg::*; ();
	logic sys_clk = 1'b0, ck_t = 1'b0, rstn = 1'b0, ce = 1'b1;
	logic cke, cs_n, ras_n, cas_n, we_n, dm, m_dqs, dq_oe, dqs_o, dqs_oe, power_down, self_refresh;
	logic [BA_W-1:0]   ba;
	logic [ADDR_W-1:0] addr, mode_reg, ext_mode_reg;
	logic [7:0]        dq_o, m_dq;
	logic [7:0]        mem [BANKS][4][8];
	logic [1:0]        r [BANKS];
	logic [2:0]        cl [BANKS];
	logic [15:0]       exp_q [$];
	int                num_errors = 0, n_tests = 0, cyc = 0;
	wire logic [7:0]   dq_i  = dq_oe ? dq_o : m_dq;
	wire logic         dqs_i = dqs_oe ? dqs_o : m_dqs;
	initial forever #10 sys_clk = ~sys_clk;
	initial begin
		#7;
		forever #32 ck_t = ~ck_t;
	end
	ddr_pin_iface DUT (.sys_clk, .rstn, .ce, .ck_t, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dm, .dq_i,
		.dq_o, .dq_oe, .dqs_i, .dqs_o, .dqs_oe, .mode_reg, .ext_mode_reg, .power_down, .self_refresh);
	ddr_ctrl_model m (.ck_t, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dm, .dq(m_dq), .dqs(m_dqs));
	// ==========
	// read monitor
	always @(posedge ck_t) begin : mon
		logic [15:0] got;
		#8;
		if (dq_oe === 1'b1) begin
			got[15:8] = dq_o;
			`CHK(dqs_o, 1'b1)
			@(negedge ck_t);
			#8 got[7:0] = dq_o;
			`CHK(dqs_o, 1'b0)
			if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
			else `CHK(got, exp_q.pop_front())
		end
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic close_out;
		$display("checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wrr(input int b, input logic [1:0] mk);
		logic [15:0] d;
		d = 16'($urandom);
		m.wr(b[1:0], {10'h0, cl[b]}, d, mk);
		if (!mk[1]) mem[b][r[b]][{cl[b][2:1], 1'b0}] = d[15:8];
		if (!mk[0]) mem[b][r[b]][{cl[b][2:1], 1'b1}] = d[7:0];
	endtask
	// close, reopen and read each bank, with a deselected read between
	task automatic rd_all;
		for (int b = 0; b < BANKS; b++) begin
			m.cmd(4'h2, b[1:0], 13'h0000, 1'b1);
			m.cmd(4'h3, b[1:0], {11'h0, r[b]}, 1'b1);
			m.cmd(4'h5, b[1:0], {10'h0, cl[b]}, 1'b1);
			exp_q.push_back({mem[b][r[b]][{cl[b][2:1], 1'b0}], mem[b][r[b]][{cl[b][2:1], 1'b1}]});
			m.cmd(4'hD, b[1:0], 13'h0000, 1'b1);
		end
		repeat (4) m.cmd(4'hF, 2'h0, 13'h0000, 1'b1);
	endtask
	initial begin
		logic [ADDR_W-1:0] v, mr, er;
		mr = MODE_RST;
		er = MODE_RST;
		void'($urandom(3624));
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk) rstn = 1'b1;
		repeat (4) @(posedge ck_t);
		for (int i = 0; i < 4; i++) begin
			v = ADDR_W'($urandom);
			m.cmd(4'h0, i[1:0], v, 1'b1);
			m.cmd(4'hF, 2'h0, 13'h0000, 1'b1);
			if (i == 0) mr = v;
			if (i == 1) er = v;
			`CHK(mode_reg, mr)
			`CHK(ext_mode_reg, er)
		end
		// frozen block: a mode set must not land
		@(negedge sys_clk) ce = 1'b0;
		repeat (3) m.cmd(4'hF, 2'h0, 13'h0000, 1'b1);
		m.cmd(4'h0, 2'h0, ~mr, 1'b1);
		m.cmd(4'hF, 2'h0, 13'h0000, 1'b1);
		`CHK(mode_reg, mr)
		@(negedge sys_clk) ce = 1'b1;
		repeat (3) m.cmd(4'hF, 2'h0, 13'h0000, 1'b1);
		for (int b = 0; b < BANKS; b++) begin
			r[b] = 2'($urandom);
			cl[b] = 3'($urandom);
			m.cmd(4'h3, b[1:0], {11'h0, r[b]}, 1'b1);
			wrr(b, 2'h0);
			wrr(b, 2'($urandom));
		end
		rd_all();
		// precharge power-down, then self refresh
		for (int k = 0; k < 2; k++) begin
			m.cmd(4'h2, 2'h0, 13'h0400, 1'b1);
			m.cmd(k ? 4'h1 : 4'hF, 2'h0, 13'h0000, 1'b0);
			repeat (3) m.cmd(4'hF, 2'h0, 13'h0000, 1'b0);
			`CHK(power_down, k == 0)
			`CHK(self_refresh, k == 1)
			repeat (8) m.cmd(4'hF, 2'h0, 13'h0000, 1'b1);
			`CHK({power_down, self_refresh}, 2'h0)
		end
		rd_all();
		`CHK(exp_q.size(), 0)
		close_out();
	end
endmodule // test_ddr_sdram_pin_interface
bind ddr_pin_iface ddr_pin_chk chk (.ck_t, .rstn, .ce, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq_oe, .dqs_o,
	.dqs_oe, .mode_reg, .ext_mode_reg, .power_down, .self_refresh);
